// file: hw/lsir_top.sv
// Link status and identification register bank on an AHB-Lite slave.
`timescale 1ns/10ps
`include "lsir_cfg.svh"
module lsir_top #(
  parameter logic [7:0] DEVICE_ID = 8'hA5, // Arbitrary value.
  parameter logic [3:0] REVISION = 4'h1, // Arbitrary value.
  parameter logic CAPABLE = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Sequence checker, same clock
  input wire logic prbsDone,
  input wire logic prbsClean,
  // Line fault detector pins
  input wire lsir_pkg::lsir_fault_t positiveWireFault,
  input wire lsir_pkg::lsir_fault_t negativeWireFault,
  // Configuration pins
  input wire logic cableTypePinLevel,
  input wire logic coaxSelectLevel,
  input wire logic controlChannelSelectLevel,
  input wire logic localControlEnableLevel,
  // Interrupt
  output logic irq
);
  import lsir_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] faultSync;
  logic [3:0] pinSync;
  logic [1:0] negFault;
  logic [1:0] posFault;

  lsir_sync #(
    .WIDTH(4),
    .RESET({`LSIR_RST_FAULT, `LSIR_RST_FAULT})
  ) u_fault_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din({negativeWireFault, positiveWireFault}),
    .dout(faultSync)
  );

  lsir_sync #(
    .WIDTH(4),
    .RESET(`LSIR_RST_PINS)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .din({cableTypePinLevel, coaxSelectLevel,
      controlChannelSelectLevel, localControlEnableLevel}),
    .dout(pinSync)
  );

  assign negFault = faultSync[3:2];
  assign posFault = faultSync[1:0];

  // ----------------------------------------------------------------
  // Sequence test pass flag
  // ----------------------------------------------------------------
  logic passFlag;
  logic next_passFlag;

  // The flag follows the checker so a later failing run drops it.
  assign next_passFlag = prbsDone && prbsClean;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      passFlag <= 1'b0;
    end else begin
      passFlag <= next_passFlag;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic [3:0] faultLast;
  logic [3:0] pinLast;
  logic passLast;
  lsir_evt_t events;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      faultLast <= {`LSIR_RST_FAULT, `LSIR_RST_FAULT};
      pinLast <= `LSIR_RST_PINS;
      passLast <= 1'b0;
    end else begin
      faultLast <= faultSync;
      pinLast <= pinSync;
      passLast <= passFlag;
    end
  end

  assign events[`LSIR_EVT_PRBS] = passFlag && !passLast;
  assign events[`LSIR_EVT_POS] = posFault != faultLast[1:0];
  assign events[`LSIR_EVT_NEG] = negFault != faultLast[3:2];
  assign events[`LSIR_EVT_PIN] = pinSync != pinLast;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wrPend;
  logic [7:0] wrIdx;
  wire addrPhase = hsel && htrans[1] && hready;
  wire [7:0] accIdx = haddr[9:2];
  wire inRange = (haddr[31:10] == `LSIR_ADDR_HI_ZERO)
    && (haddr[1:0] == `LSIR_WORD_ALIGN);
  wire rdAccept = addrPhase && !hwrite;
  wire wrAccept = addrPhase && hwrite && inRange;
  wire rdStatus = rdAccept && inRange
    && (accIdx == `LSIR_IDX_IRQ_STATUS);
  // Only the mask is writable; every other index drops the data.
  wire maskWrite = wrPend && (wrIdx == `LSIR_IDX_IRQ_MASK);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPend <= 1'b0;
      wrIdx <= `LSIR_ZERO_BYTE;
    end else begin
      wrPend <= wrAccept;
      wrIdx <= accIdx;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt collector
  // ----------------------------------------------------------------
  lsir_irq_if irqLink();

  assign irqLink.event_in = events;
  assign irqLink.readClear = rdStatus;
  assign irqLink.maskWe = maskWrite;
  assign irqLink.maskIn = hwdata[3:0];

  lsir_irq u_irq (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .link(irqLink)
  );

  assign irq = irqLink.irq;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  lsir_byte_t linkByte;
  lsir_byte_t pinByte;
  lsir_byte_t capByte;
  lsir_evt_t maskView;
  lsir_byte_t readMux;

  assign linkByte = {passFlag, `LSIR_ZERO_TRI, negFault, posFault};
  assign pinByte = {pinSync, `LSIR_ZERO_NIB};
  assign capByte = {`LSIR_ZERO_TRI, CAPABLE, REVISION};
  // A mask write in its data phase is seen by a read right behind it.
  assign maskView = maskWrite ? hwdata[3:0] : irqLink.mask;

  always_comb begin
    readMux = `LSIR_ZERO_BYTE;
    if (!inRange) begin
      readMux = `LSIR_ZERO_BYTE;
    end else if (accIdx == `LSIR_IDX_LINK) begin
      readMux = linkByte;
    end else if (accIdx == `LSIR_IDX_RSVD_A) begin
      readMux = `LSIR_RST_RSVD_A;
    end else if (accIdx == `LSIR_IDX_RSVD_B) begin
      readMux = `LSIR_RST_RSVD_B;
    end else if (accIdx == `LSIR_IDX_RSVD_C) begin
      readMux = `LSIR_RST_RSVD_C;
    end else if (accIdx == `LSIR_IDX_RSVD_D) begin
      readMux = `LSIR_RST_RSVD_D;
    end else if (accIdx == `LSIR_IDX_RSVD_E) begin
      readMux = `LSIR_RST_RSVD_E;
    end else if (accIdx == `LSIR_IDX_RSVD_F) begin
      readMux = `LSIR_RST_RSVD_F;
    end else if (accIdx == `LSIR_IDX_RSVD_G) begin
      readMux = `LSIR_RST_RSVD_G;
    end else if (accIdx == `LSIR_IDX_RSVD_H) begin
      readMux = `LSIR_RST_RSVD_H;
    end else if (accIdx == `LSIR_IDX_PINS) begin
      readMux = pinByte;
    end else if (accIdx == `LSIR_IDX_IDENT) begin
      readMux = DEVICE_ID;
    end else if (accIdx == `LSIR_IDX_CAPREV) begin
      readMux = capByte;
    end else if (accIdx == `LSIR_IDX_IRQ_STATUS) begin
      readMux = {`LSIR_ZERO_NIB, irqLink.status};
    end else if (accIdx == `LSIR_IDX_IRQ_MASK) begin
      readMux = {`LSIR_ZERO_NIB, maskView};
    end else begin
      readMux = `LSIR_ZERO_BYTE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hrdata <= `LSIR_ZERO_WORD;
    end else if (rdAccept) begin
      hrdata <= {`LSIR_PAD_WORD, readMux};
    end
  end

  // Every access completes with no wait state and an OKAY answer.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [1:0] age;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      age <= `LSIR_ZERO_PAIR;
    end else if (age != `LSIR_AGE_FULL) begin
      age <= age + `LSIR_AGE_STEP;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_pass_flag_cause: assert property (
    passFlag |-> $past(prbsDone && prbsClean))
    else $error("Pass flag set without a clean finished test.");

  a_pass_flag_rise: assert property (
    (prbsDone && prbsClean) |=> passFlag)
    else $error("Clean finished test did not raise the pass flag.");

  // The status bit may already be set, so only its presence is checked.
  a_pass_event_set: assert property (
    (passFlag && !passLast) |=> irqLink.status[`LSIR_EVT_PRBS])
    else $error("Pass flag rise did not set its status bit.");

  a_status_sticky: assert property (
    (|irqLink.status && !rdStatus) |=>
      ((irqLink.status & $past(irqLink.status)) == $past(irqLink.status)))
    else $error("Status bit dropped without a status read.");

  a_mask_write_take: assert property (
    maskWrite |=> irqLink.mask == $past(hwdata[3:0]))
    else $error("Mask write did not store its data.");

  a_neg_fault_path: assert property (
    (age == `LSIR_AGE_FULL) |->
      negFault == $past(negativeWireFault, 2))
    else $error("Negative wire code does not follow its pins.");

  a_pos_fault_path: assert property (
    (age == `LSIR_AGE_FULL) |->
      posFault == $past(positiveWireFault, 2))
    else $error("Positive wire code does not follow its pins.");

  a_pin_level_read: assert property (
    (rdAccept && inRange && accIdx == `LSIR_IDX_PINS) |=>
      hrdata[3:0] == `LSIR_ZERO_NIB
      && hrdata[7:4] == $past(pinSync))
    else $error("Pin status read returns wrong levels.");

  a_ident_read: assert property (
    (rdAccept && inRange && accIdx == `LSIR_IDX_IDENT) |=>
      hrdata == {`LSIR_PAD_WORD, DEVICE_ID})
    else $error("Identifier read returns wrong value.");

  a_write_no_effect: assert property (
    (wrPend && wrIdx != `LSIR_IDX_IRQ_MASK) |=>
      $stable(irqLink.mask))
    else $error("Write to a read-only index changed the mask.");

  a_status_read_clear: assert property (
    (rdStatus && events == `LSIR_RST_STATUS) |=>
      irqLink.status == `LSIR_RST_STATUS)
    else $error("Status read did not clear the status.");

  a_irq_level_out: assert property (
    $rose(irq) |-> $past(|events) || $past(maskWrite))
    else $error("Interrupt rose with no event and no mask write.");

  c_pass_read: cover property (
    passFlag ##1 (rdAccept && accIdx == `LSIR_IDX_LINK));
  c_fault_open: cover property (negFault == FAULT_OPEN);
  c_irq_cleared: cover property (irq ##1 rdStatus ##1 !irq);
  c_write_read: cover property (maskWrite && rdAccept);
endmodule // lsir_top

// file: hw/lsir_cfg.svh
// Register indices, reset values and field positions of the status bank.
`ifndef LSIR_CFG_SVH
`define LSIR_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LSIR_IDX_LINK 8'h14
`define LSIR_IDX_RSVD_A 8'h15
`define LSIR_IDX_RSVD_B 8'h16
`define LSIR_IDX_RSVD_C 8'h17
`define LSIR_IDX_RSVD_D 8'h18
`define LSIR_IDX_RSVD_E 8'h19
`define LSIR_IDX_RSVD_F 8'h1A
`define LSIR_IDX_RSVD_G 8'h1B
`define LSIR_IDX_RSVD_H 8'h1C
`define LSIR_IDX_PINS 8'h1D
`define LSIR_IDX_IDENT 8'h1E
`define LSIR_IDX_CAPREV 8'h1F
`define LSIR_IDX_IRQ_STATUS 8'h20
`define LSIR_IDX_IRQ_MASK 8'h21

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
`define LSIR_ADDR_HI_ZERO 22'h0
`define LSIR_WORD_ALIGN 2'h0

// ----------------------------------------------------------------
// Reset and fixed read values
// ----------------------------------------------------------------
`define LSIR_RST_RSVD_A 8'h20
`define LSIR_RST_RSVD_B 8'h30
`define LSIR_RST_RSVD_C 8'h54
`define LSIR_RST_RSVD_D 8'h30
`define LSIR_RST_RSVD_E 8'hC8
`define LSIR_RST_RSVD_F 8'h00
`define LSIR_RST_RSVD_G 8'h00
`define LSIR_RST_RSVD_H 8'h00
`define LSIR_RST_FAULT 2'h2
`define LSIR_RST_PINS 4'h0
`define LSIR_RST_MASK 4'h0
`define LSIR_RST_STATUS 4'h0
`define LSIR_ZERO_BYTE 8'h00
`define LSIR_ZERO_WORD 32'h0
`define LSIR_PAD_WORD 24'h0
`define LSIR_ZERO_NIB 4'h0
`define LSIR_ZERO_TRI 3'h0
`define LSIR_ZERO_PAIR 2'h0

// ----------------------------------------------------------------
// Event bits of the interrupt status register
// ----------------------------------------------------------------
`define LSIR_EVT_W 4
`define LSIR_EVT_PRBS 0
`define LSIR_EVT_POS 1
`define LSIR_EVT_NEG 2
`define LSIR_EVT_PIN 3

// ----------------------------------------------------------------
// Synchroniser warm-up count used by checks
// ----------------------------------------------------------------
`define LSIR_AGE_FULL 2'h3
`define LSIR_AGE_STEP 2'h1

`endif

// file: hw/lsir_pkg.sv
// Types shared by the status bank modules.
package lsir_pkg;

  typedef logic [7:0] lsir_byte_t;
  typedef logic [3:0] lsir_evt_t;

  typedef enum logic [1:0] {
    FAULT_SUPPLY = 2'h0,
    FAULT_GROUND = 2'h1,
    FAULT_NORMAL = 2'h2,
    FAULT_OPEN = 2'h3
  } lsir_fault_t;

endpackage

// file: hw/lsir_irq_if.sv
// Carrier between the register bank and its interrupt collector.
`timescale 1ns/10ps
interface lsir_irq_if;
  import lsir_pkg::*;
  lsir_evt_t event_in;
  logic readClear;
  logic maskWe;
  lsir_evt_t maskIn;
  lsir_evt_t status;
  lsir_evt_t mask;
  logic irq;

  modport bank (output event_in, output readClear, output maskWe,
    output maskIn, input status, input mask, input irq);
  modport collector (input event_in, input readClear, input maskWe,
    input maskIn, output status, output mask, output irq);
endinterface

// file: hw/lsir_sync.sv
// Two-stage synchroniser for pin levels.
`timescale 1ns/10ps
module lsir_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1 <= RESET;
      dout <= RESET;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule // lsir_sync

// file: hw/lsir_irq.sv
// Sticky interrupt status, mask and level interrupt output.
`timescale 1ns/10ps
`include "lsir_cfg.svh"
module lsir_irq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Bank side
  lsir_irq_if.collector link
);
  import lsir_pkg::*;

  lsir_evt_t status;
  lsir_evt_t mask;
  lsir_evt_t next_status;

  // A new event in the clearing cycle must survive the read.
  assign next_status = (link.readClear ? `LSIR_RST_STATUS : status)
    | link.event_in;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      status <= `LSIR_RST_STATUS;
      mask <= `LSIR_RST_MASK;
    end else begin
      status <= next_status;
      if (link.maskWe) begin
        mask <= link.maskIn;
      end
    end
  end

  assign link.status = status;
  assign link.mask = mask;
  assign link.irq = |(status & mask);
endmodule // lsir_irq

// file: verification/tb.sv
// Self-checking bench for the link status and identifier bank.
`timescale 1ns/10ps
module tb;
  import lsir_pkg::*;

  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk_sys;
  logic nrst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic prbsDone;
  logic prbsClean;
  lsir_fault_t posFault;
  lsir_fault_t negFault;
  logic [3:0] pins;
  logic irq;
  logic [31:0] rd;
  int errors;
  int num_checks;
  localparam logic [7:0] RSVD [0:7] = '{8'h20, 8'h30, 8'h54, 8'h30,
    8'hC8, 8'h00, 8'h00, 8'h00};

  // Single slave, so its ready is the bus ready.
  assign hready = hreadyout;

  lsir_top i_lsir_top (
    .clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .prbsDone(prbsDone), .prbsClean(prbsClean),
    .positiveWireFault(posFault), .negativeWireFault(negFault),
    .cableTypePinLevel(pins[3]), .coaxSelectLevel(pins[2]),
    .controlChannelSelectLevel(pins[1]),
    .localControlEnableLevel(pins[0]), .irq(irq)
  );

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      errors++;
    end
  endtask

  // One single-word transfer; waits on ready in both phases.
  task automatic bus(input logic wr, input logic [31:0] a,
    input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hready !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, {22'h0, idx, 2'h0}, 32'h0);
    chk(rd, {24'h0, exp});
  endtask

  // Pin inputs pass two synchroniser stages before they show.
  task automatic settle;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic check_idle;
    rdchk(8'h14, 8'h0A);
    for (int i = 0; i < 8; i++) begin
      rdchk(8'h15 + 8'(i), RSVD[i]);
    end
    rdchk(8'h1D, 8'h00);
    rdchk(8'h1E, 8'hA5);
    rdchk(8'h1F, 8'h01);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic test_pass;
    prbsDone <= 1'b1;
    prbsClean <= 1'b0;
    settle();
    rdchk(8'h14, 8'h0A);
    prbsClean <= 1'b1;
    settle();
    rdchk(8'h14, 8'h8A);
    prbsDone <= 1'b0;
    settle();
    rdchk(8'h14, 8'h0A);
    prbsClean <= 1'b0;
    $display("test pass_flag done");
  endtask

  task automatic test_faults;
    logic [1:0] f;
    for (int i = 0; i < 4; i++) begin
      f = i[1:0];
      posFault <= lsir_fault_t'(f);
      negFault <= lsir_fault_t'(~f);
      settle();
      rdchk(8'h14, {4'h0, ~f, f});
    end
    posFault <= FAULT_NORMAL;
    negFault <= FAULT_NORMAL;
    settle();
    $display("test faults done");
  endtask

  task automatic test_pins;
    for (int i = 0; i < 4; i++) begin
      pins <= 4'h1 << i;
      settle();
      rdchk(8'h1D, {4'h1 << i, 4'h0});
    end
    pins <= 4'h0;
    settle();
    $display("test pins done");
  endtask

  // Every read-only place from 0x14 to 0x1F, reserved ones too, must shrug off writes.
  task automatic test_writes;
    for (int i = 8'h14; i <= 8'h1F; i++) begin
      bus(1'b1, {22'h0, 8'(i), 2'h0}, 32'hFFFFFFFF);
    end
    check_idle();
    $display("test writes done");
  endtask

  task automatic test_unmapped;
    bus(1'b0, 32'h88, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h51, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 32'h450, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test unmapped done");
  endtask

  task automatic test_irq;
    bus(1'b0, 32'h80, 32'h0);
    bus(1'b1, 32'h84, 32'h1);
    rdchk(8'h21, 8'h01);
    chk({31'h0, irq}, 32'h0);
    prbsDone <= 1'b1;
    prbsClean <= 1'b1;
    settle();
    chk({31'h0, irq}, 32'h1);
    rdchk(8'h20, 8'h01);
    chk({31'h0, irq}, 32'h0);
    prbsDone <= 1'b0;
    prbsClean <= 1'b0;
    bus(1'b1, 32'h84, 32'h0);
    pins <= 4'h8;
    settle();
    chk({31'h0, irq}, 32'h0);
    rdchk(8'h20, 8'h08);
    pins <= 4'h0;
    settle();
    bus(1'b0, 32'h80, 32'h0);
    $display("test irq done");
  endtask

  // A reset in mid-run must drop the mask and pending status too.
  task automatic test_midreset;
    bus(1'b1, 32'h84, 32'hF);
    pins <= 4'hF;
    settle();
    nrst <= 1'b0;
    pins <= 4'h0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    check_idle();
    rdchk(8'h21, 8'h00);
    rdchk(8'h20, 8'h00);
    chk({31'h0, irq}, 32'h0);
    $display("test mid_reset done");
  endtask

  // --------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // The whole run needs well under two thousand cycles.
  initial begin
    #500000;
    errors++;
    stop_test();
  end

  initial begin
    errors = 0;
    num_checks = 0;
    nrst = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    prbsDone = 1'b0;
    prbsClean = 1'b0;
    posFault = FAULT_NORMAL;
    negFault = FAULT_NORMAL;
    pins = 4'h0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    check_idle();
    $display("test reset_values done");
    test_pass();
    test_faults();
    test_pins();
    test_writes();
    test_unmapped();
    test_irq();
    test_midreset();
    stop_test();
  end
endmodule // tb
